// [rtl/ppc_pkg.sv]
// constants and types for the playback path configuration bank
package ppc_pkg;
  // field positions, word a
  localparam int A_VOL_PD  = 0;
  localparam int A_AMP_LO  = 1;
  localparam int A_AMP_HI  = 2;
  localparam int A_OMUX_LO = 3;
  localparam int A_OMUX_HI = 4;
  localparam int A_OSC_PD  = 8;
  // field positions, word b
  localparam int B_LPF_PD  = 1;
  localparam int B_RATE_LO = 2;
  localparam int B_RATE_HI = 3;
  localparam int B_FSRC    = 4;
  localparam int B_S2M_LO  = 5;
  localparam int B_S2M_HI  = 6;
  localparam int B_ATT_LO  = 11;
  localparam int B_ATT_HI  = 13;
  localparam int B_VMUX_LO = 14;
  localparam int B_VMUX_HI = 15;
  // reset values: stages powered down
  localparam logic [15:0] RST_WORD_A = 16'h0101;
  localparam logic [15:0] RST_WORD_B = 16'h0002;
  localparam logic [15:0] RST_WORD_C = 16'h0000;
  // word indices and counts
  localparam logic [1:0] IDX_A    = 2'h0;
  localparam logic [1:0] IDX_B    = 2'h1;
  localparam logic [1:0] IDX_C    = 2'h2;
  localparam logic [1:0] IDX_DONE = 2'h3;
  localparam logic [2:0] RD_LAST  = 3'h5;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [4:0] ATT_STEP_DB = 5'h04;
  // arbitrary neutral bus address
  localparam logic [6:0] DEV_ADDR = 7'h2c;

  typedef enum logic [1:0] {
    PPC_RATE_8K0 = 2'b00,
    PPC_RATE_6K4 = 2'b01,
    PPC_RATE_5K3 = 2'b10,
    PPC_RATE_4K0 = 2'b11
  } ppc_rate_type;

  typedef struct packed {
    logic         filter_from_storage;
    logic         lowpass_on;
    ppc_rate_type rate;
    logic [1:0]   second_mixer_sel;
    logic         second_mixer_lpf_only;
    logic [1:0]   volume_mux_sel;
    logic         volume_from_mixer2;
    logic         volume_on;
    logic [2:0]   atten_code;
    logic [4:0]   atten_db;
    logic [1:0]   output_mux_sel;
    logic         out_from_volume;
    logic         out_from_converter;
    logic [1:0]   out_amp_mode;
    logic         speaker_on;
    logic         speaker_high_gain;
    logic         aux_on;
    logic         oscillator_on;
  } ppc_path_type;
endpackage

// [rtl/ppc_playback_path_config_regs.sv]
// two-wire configuration slave and playback path decode
`timescale 1ns/1ps
`default_nettype none
module ppc_playback_path_config_regs (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          scl_i,
  input  wire logic          sda_i,
  output logic               sda_o,
  output logic               sda_oe,
  output logic [15:0]        word_a,
  output logic [15:0]        word_b,
  output logic [15:0]        word_c,
  output ppc_pkg::ppc_path_type path
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_CHK, ST_ADDR_ACK,
    ST_WR, ST_WR_CHK, ST_WR_ACK,
    ST_RD, ST_RD_ACK, ST_RD_NEXT
  } ppc_state_type;

  // read byte order: a hi, a lo, b hi, b lo, c hi, c lo
  function automatic logic [7:0] rd_byte(
    input logic [2:0]  idx,
    input logic [15:0] wa,
    input logic [15:0] wb,
    input logic [15:0] wc
  );
    logic [15:0] w;
    case (idx[2:1])
      2'h0:    w = wa;
      2'h1:    w = wb;
      default: w = wc;
    endcase
    rd_byte = idx[0] ? w[7:0] : w[15:8];
  endfunction

  // pin synchronisers; stage 1 feeds stage 2 only
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s2_r & ~scl_s3_r;
  assign scl_fall  = ~scl_s2_r & scl_s3_r;
  assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign bus_stop  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

  ppc_state_type state_r, state_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [7:0]  hold_r, hold_nxt;
  logic        hi_r, hi_nxt;
  logic        ack_r, ack_nxt;
  logic        rw_r, rw_nxt;
  logic        drive_r, drive_nxt;
  logic [1:0]  ptr_r, ptr_nxt;
  logic [2:0]  ridx_r, ridx_nxt;
  logic [15:0] wa_r, wa_nxt;
  logic [15:0] wb_r, wb_nxt;
  logic [15:0] wc_r, wc_nxt;
  logic [7:0]  shin;
  logic [7:0]  tx;

  assign shin = {shift_r[6:0], sda_s2_r};
  assign tx   = rd_byte(ridx_r, wa_r, wb_r, wc_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    hold_nxt  = hold_r;
    hi_nxt    = hi_r;
    ack_nxt   = ack_r;
    rw_nxt    = rw_r;
    drive_nxt = drive_r;
    ptr_nxt   = ptr_r;
    ridx_nxt  = ridx_r;
    wa_nxt    = wa_r;
    wb_nxt    = wb_r;
    wc_nxt    = wc_r;
    if (bus_start) begin
      // every transaction restarts at word a
      state_nxt = ST_ADDR;
      cnt_nxt   = 3'h0;
      drive_nxt = 1'b0;
      ptr_nxt   = ppc_pkg::IDX_A;
      hi_nxt    = 1'b0;
      ridx_nxt  = 3'h0;
    end else if (bus_stop) begin
      // a half-written word is dropped, never applied
      state_nxt = ST_IDLE;
      drive_nxt = 1'b0;
      hi_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          drive_nxt = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_nxt = shin;
            cnt_nxt   = cnt_r + 3'h1;
            if (cnt_r == ppc_pkg::BIT_LAST) begin
              state_nxt = ST_ADDR_CHK;
            end
          end
        end
        ST_ADDR_CHK: begin
          if (scl_fall) begin
            if (shift_r[7:1] == ppc_pkg::DEV_ADDR) begin
              drive_nxt = 1'b1;
              rw_nxt    = shift_r[0];
              state_nxt = ST_ADDR_ACK;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 3'h0;
            if (rw_r) begin
              shift_nxt = tx;
              drive_nxt = ~tx[7];
              state_nxt = ST_RD;
            end else begin
              drive_nxt = 1'b0;
              state_nxt = ST_WR;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            shift_nxt = shin;
            cnt_nxt   = cnt_r + 3'h1;
            if (cnt_r == ppc_pkg::BIT_LAST) begin
              state_nxt = ST_WR_CHK;
              ack_nxt   = (ptr_r != ppc_pkg::IDX_DONE);
              if (ptr_r != ppc_pkg::IDX_DONE) begin
                if (!hi_r) begin
                  hold_nxt = shin;
                  hi_nxt   = 1'b1;
                end else begin
                  // whole word lands on this scl rise
                  hi_nxt  = 1'b0;
                  ptr_nxt = ptr_r + 2'h1;
                  case (ptr_r)
                    ppc_pkg::IDX_A: wa_nxt = {hold_r, shin};
                    ppc_pkg::IDX_B: wb_nxt = {hold_r, shin};
                    ppc_pkg::IDX_C: wc_nxt = {hold_r, shin};
                    default: ;
                  endcase
                end
              end
            end
          end
        end
        ST_WR_CHK: begin
          if (scl_fall) begin
            drive_nxt = ack_r;
            state_nxt = ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            drive_nxt = 1'b0;
            cnt_nxt   = 3'h0;
            state_nxt = ack_r ? ST_WR : ST_IDLE;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == ppc_pkg::BIT_LAST) begin
              drive_nxt = 1'b0;
              state_nxt = ST_RD_ACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              drive_nxt = ~shift_r[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            if (sda_s2_r) begin
              state_nxt = ST_IDLE;
            end else begin
              ridx_nxt  = (ridx_r == ppc_pkg::RD_LAST) ?
                          3'h0 : ridx_r + 3'h1;
              state_nxt = ST_RD_NEXT;
            end
          end
        end
        ST_RD_NEXT: begin
          if (scl_fall) begin
            shift_nxt = tx;
            drive_nxt = ~tx[7];
            cnt_nxt   = 3'h0;
            state_nxt = ST_RD;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          drive_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 3'h0;
      shift_r <= 8'h00;
      hold_r  <= 8'h00;
      hi_r    <= 1'b0;
      ack_r   <= 1'b0;
      rw_r    <= 1'b0;
      drive_r <= 1'b0;
      ptr_r   <= ppc_pkg::IDX_A;
      ridx_r  <= 3'h0;
      wa_r    <= ppc_pkg::RST_WORD_A;
      wb_r    <= ppc_pkg::RST_WORD_B;
      wc_r    <= ppc_pkg::RST_WORD_C;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shift_r <= shift_nxt;
      hold_r  <= hold_nxt;
      hi_r    <= hi_nxt;
      ack_r   <= ack_nxt;
      rw_r    <= rw_nxt;
      drive_r <= drive_nxt;
      ptr_r   <= ptr_nxt;
      ridx_r  <= ridx_nxt;
      wa_r    <= wa_nxt;
      wb_r    <= wb_nxt;
      wc_r    <= wc_nxt;
    end
  end

  // open drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = drive_r;
  assign word_a = wa_r;
  assign word_b = wb_r;
  assign word_c = wc_r;

  // path decode, registered one cycle after the word
  ppc_pkg::ppc_path_type path_r, path_nxt;
  logic [1:0] amp;

  always_comb begin
    amp = wa_r[ppc_pkg::A_AMP_HI:ppc_pkg::A_AMP_LO];
    path_nxt = '0;
    path_nxt.filter_from_storage = wb_r[ppc_pkg::B_FSRC];
    path_nxt.lowpass_on = ~wb_r[ppc_pkg::B_LPF_PD];
    path_nxt.rate = ppc_pkg::ppc_rate_type'(
      wb_r[ppc_pkg::B_RATE_HI:ppc_pkg::B_RATE_LO]);
    path_nxt.second_mixer_sel =
      wb_r[ppc_pkg::B_S2M_HI:ppc_pkg::B_S2M_LO];
    path_nxt.second_mixer_lpf_only =
      (wb_r[ppc_pkg::B_S2M_HI:ppc_pkg::B_S2M_LO] == 2'b10);
    path_nxt.volume_mux_sel =
      wb_r[ppc_pkg::B_VMUX_HI:ppc_pkg::B_VMUX_LO];
    path_nxt.volume_from_mixer2 =
      (wb_r[ppc_pkg::B_VMUX_HI:ppc_pkg::B_VMUX_LO] == 2'b01);
    path_nxt.volume_on = ~wa_r[ppc_pkg::A_VOL_PD];
    path_nxt.atten_code =
      wb_r[ppc_pkg::B_ATT_HI:ppc_pkg::B_ATT_LO];
    path_nxt.atten_db = 5'(ppc_pkg::ATT_STEP_DB *
      {2'b00, wb_r[ppc_pkg::B_ATT_HI:ppc_pkg::B_ATT_LO]});
    path_nxt.output_mux_sel =
      wa_r[ppc_pkg::A_OMUX_HI:ppc_pkg::A_OMUX_LO];
    path_nxt.out_from_volume =
      (wa_r[ppc_pkg::A_OMUX_HI:ppc_pkg::A_OMUX_LO] == 2'b00);
    path_nxt.out_from_converter =
      (wa_r[ppc_pkg::A_OMUX_HI:ppc_pkg::A_OMUX_LO] == 2'b01);
    path_nxt.out_amp_mode = amp;
    path_nxt.speaker_on = (amp == 2'b01);
    path_nxt.speaker_high_gain = (amp == 2'b01);
    // only mode 10 is taken to enable aux here
    path_nxt.aux_on = (amp == 2'b10);
    path_nxt.oscillator_on = ~wa_r[ppc_pkg::A_OSC_PD];
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      path_r <= '0;
    end else begin
      path_r <= path_nxt;
    end
  end

  assign path = path_r;

endmodule
`default_nettype wire

// [sim/ppc_host_model.sv]
// two-wire host model driving the configuration bus
`timescale 1ns/1ps
`default_nettype none
module ppc_host_model (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  localparam int HALF = 6; // margin over the input synchroniser
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask
  // word order a, b, c is left to the caller
  task automatic start();
    sda_low <= 1'b1;
    hold(HALF);
    scl <= 1'b0;
    hold(1);
  endtask
  task automatic bit_io(input logic b, output logic got);
    sda_low <= ~b;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    got = sda; // end of high phase, settled
    scl <= 1'b0;
    hold(1);
  endtask
  task automatic xfer(input logic [7:0] b, input logic a9,
                      output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], got[i]);
    bit_io(a9, ack);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    sda_low <= 1'b0;
    hold(HALF);
  endtask
endmodule
`default_nettype wire

// [sim/ppc_playback_monitor.sv]
// assertions on the playback path decode
`timescale 1ns/1ps
`default_nettype none
module ppc_playback_monitor (
  input wire logic                  clock,
  input wire logic                  rstn,
  input wire logic [15:0]           word_a,
  input wire logic [15:0]           word_b,
  input wire ppc_pkg::ppc_path_type path
);
  logic live_r;
  // path is held at zero in reset, so skip the release edge
  always_ff @(posedge clock) begin
    live_r <= rstn;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn || !live_r);
  // path lags the words by one clock
  sequence s_amp01;
    $past(word_a[2:1]) == 2'b01;
  endsequence
  sequence s_omux01;
    $past(word_a[4:3]) == 2'b01;
  endsequence
  a_src_sel: assert property (
    ##1 path.filter_from_storage == $past(word_b[4]))
    else $error("filter source wrong");
  a_lpf_power: assert property (
    ##1 path.lowpass_on == !$past(word_b[1])) else $error("lowpass power");
  a_rate_code: assert property (
    ##1 path.rate == $past(word_b[3:2])) else $error("rate wrong");
  a_mix2_only: assert property (
    ##1 path.second_mixer_lpf_only == ($past(word_b[6:5]) == 2'b10))
    else $error("mixer two select");
  a_vmux_mix2: assert property (
    ##1 path.volume_from_mixer2 == ($past(word_b[15:14]) == 2'b01))
    else $error("volume mux");
  a_power_bits: assert property (
    ##1 {path.volume_on, path.oscillator_on}
        == ~{$past(word_a[0]), $past(word_a[8])}) else $error("power bits");
  a_atten_step: assert property (
    ##1 {path.atten_code, path.atten_db}
        == {$past(word_b[13:11]), $past(word_b[13:11]), 2'b00})
    else $error("attenuation");
  a_omux_vol: assert property (
    ##1 path.out_from_volume == ($past(word_a[4:3]) == 2'b00))
    else $error("output mux");
  a_omux_conv: assert property (
    s_omux01 |-> path.out_from_converter) else $error("converter path");
  a_amp_gain: assert property (
    s_amp01 |-> path.speaker_on && path.speaker_high_gain && !path.aux_on)
    else $error("amp mode");
  a_raw_sels: assert property (
    ##1 {path.second_mixer_sel, path.volume_mux_sel,
         path.output_mux_sel, path.out_amp_mode}
        == {$past(word_b[6:5]), $past(word_b[15:14]),
            $past(word_a[4:3]), $past(word_a[2:1])})
    else $error("raw selects");
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the playback path configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_top;
  localparam logic [7:0] WR = {ppc_pkg::DEV_ADDR, 1'b0};
  logic                  clock;
  logic                  rstn;
  logic                  scl;
  logic                  sda_low;
  logic                  sda_o;
  logic                  sda_oe;
  logic [15:0]           word_a;
  logic [15:0]           word_b;
  logic [15:0]           word_c;
  ppc_pkg::ppc_path_type path;
  wire logic             sda_line;
  int                    miscompares;
  int                    checks_done;
  logic [47:0]           notes[$];
  logic [47:0]           prev;
  logic [47:0]           model;
  logic [47:0]           exp_w;
  logic [7:0]            rd;
  logic                  ack;

  assign sda_line = ~(sda_low | (sda_oe & ~sda_o)); // pull-up when free
  ppc_playback_path_config_regs u_dut (
    .clock(clock), .rstn(rstn), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .word_a(word_a), .word_b(word_b),
    .word_c(word_c), .path(path));
  ppc_host_model u_host (
    .clock(clock), .sda(sda_line), .scl(scl), .sda_low(sda_low));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // every word change must match the oldest note
  always @(posedge clock) begin
    if (rstn === 1'b1 && {word_a, word_b, word_c} !== prev) begin
      exp_w = notes.size() > 0 ? notes.pop_front() : ~prev;
      `CHK({word_a, word_b, word_c}, exp_w)
    end
    prev <= {word_a, word_b, word_c};
  end
  task automatic wr(input logic [7:0] adr, input logic [47:0] w,
                    input int n);
    logic        ok;
    logic [47:0] m;
    ok = adr == WR;
    m = model;
    u_host.start();
    u_host.xfer(adr, 1'b1, rd, ack);
    `CHK(ack, !ok)
    for (int k = 0; k < n; k++) begin
      if (ok && k % 2 == 1 && k < 6) begin
        m[47 - 16 * (k / 2) -: 16] = w[47 - 16 * (k / 2) -: 16];
        notes.push_back(m);
      end
      u_host.xfer(w[47 - 8 * (k % 6) -: 8], 1'b1, rd, ack);
      `CHK(ack, !ok || k >= 6)
    end
    u_host.stop();
    model = m;
  endtask
  task automatic rd_chk(input int n);
    u_host.start();
    u_host.xfer({ppc_pkg::DEV_ADDR, 1'b1}, 1'b1, rd, ack);
    `CHK(ack, 1'b0)
    for (int k = 0; k < n; k++) begin
      u_host.xfer(8'hff, k == n - 1, rd, ack);
      `CHK(rd, model[47 - 8 * (k % 6) -: 8])
    end
    u_host.stop();
  endtask
  task automatic results();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    results();
  end
  initial begin
    logic [47:0] r;
    logic [7:0]  pv;
    rstn = 1'b0;
    miscompares = 0;
    checks_done = 0;
    model = {ppc_pkg::RST_WORD_A, ppc_pkg::RST_WORD_B, ppc_pkg::RST_WORD_C};
    void'($urandom(32'h5044));
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK({word_a, word_b, word_c}, model)
    wr(WR, 48'h2422_59d1_0003, 6);
    repeat (2) @(posedge clock);
    `CHK({path.filter_from_storage, path.rate, path.atten_db}, 8'h8c)
    pv = {path.lowpass_on, path.second_mixer_lpf_only,
          path.volume_from_mixer2, path.volume_on, path.out_from_volume,
          path.speaker_high_gain, path.aux_on, path.oscillator_on};
    `CHK(pv, 8'hfd)
    rd_chk(7);
    // sweep every attenuation, rate, output mux and amp code
    for (int i = 0; i < 8; i++) begin
      r[47:16] = $urandom;
      r[15:0] = 16'($urandom);
      r[29:27] = i[2:0];
      r[19:18] = i[1:0];
      r[36:33] = {i[1:0], i[2:1]};
      wr(WR, r, 6);
    end
    rd_chk(6);
    wr(WR ^ 8'h02, ~r, 2);
    wr(WR, ~r, 7);
    wr(WR, r, 3);
    rd_chk(6);
    results();
  end
endmodule
bind ppc_playback_path_config_regs ppc_playback_monitor u_mon (
  .clock(clock), .rstn(rstn), .word_a(word_a), .word_b(word_b),
  .path(path));
`default_nettype wire
